// ### bench/host_cpu_model.sv
`timescale 1ns/1ps
// ====
// host cpu on the byte-wide port
module host_cpu_model (
  // clock
  input wire logic mclk,
  // pins toward the device
  output logic chip_enable_low,
  output logic read_strobe_low,
  output logic write_strobe_low,
  output logic [2:0] host_addr,
  output logic [7:0] data_in,
  // read data back
  input wire logic [7:0] data_out
);
  localparam int HOLD = 30; // 150 ns at 200 MHz
  // idle: strobes high
  initial begin
    {chip_enable_low, read_strobe_low, write_strobe_low} = 3'h7;
    host_addr = 3'h0;
    data_in = 8'h00;
  end
  // released lines show the inverse, no pull on the bus
  task automatic access(input logic rd, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk);
    host_addr = a;
    data_in = d;
    {chip_enable_low, read_strobe_low, write_strobe_low} = {1'b0, !rd, rd};
    repeat (HOLD) @(negedge mclk);
    q = data_out;
    {chip_enable_low, read_strobe_low, write_strobe_low} = 3'h7;
    host_addr = ~a;
    data_in = ~d;
    repeat (HOLD) @(negedge mclk);
  endtask : access
endmodule : host_cpu_model

// ### bench/uart_irq_and_host_access_sva.sv
`timescale 1ns/1ps
// ====
// checker on the interrupt block ports
module irq_host_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // host side
  input wire logic chip_enable_low,
  input wire logic read_strobe_low,
  input wire logic data_oe,
  input wire logic rx_holding_read,
  input wire logic tx_holding_write,
  input wire logic ct_stop,
  // interrupt side
  input wire logic irq_out_low,
  input wire logic [7:0] irq_mask_reg,
  input wire logic [7:0] irq_status_reg
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // pin registered from status and mask, one edge late
  irq_level_a: assert property (
    !irq_out_low == |($past(irq_status_reg) & $past(irq_mask_reg)))
    else $error("irq pin off masked status");
  rx_withdraw_a: assert property (rx_holding_read |->
    ##[0:2] !irq_status_reg[2]) else $error("rx bit kept");
  tx_withdraw_a: assert property (tx_holding_write |->
    ##[0:2] irq_status_reg[1:0] == 2'h0) else $error("tx bits kept");
  cnt_withdraw_a: assert property (ct_stop |->
    ##[0:2] !irq_status_reg[4]) else $error("counter bit kept");
  // a mask write that leaves nothing enabled frees the pin next edge
  mask_withdraw_a: assert property ($changed(irq_mask_reg) &&
    !(|(irq_mask_reg & irq_status_reg)) |=> irq_out_low)
    else $error("pin held after mask clear");
  // strobes pass a synchroniser, so a read needs pins low earlier
  read_live_a: assert property ($rose(data_oe) |->
    !$past(chip_enable_low, 3) && !$past(read_strobe_low, 3))
    else $error("read without strobes");
  spare_bit_a: assert property (irq_status_reg[7] == 1'b0)
    else $error("spare status bit set");
  stop_pulse_a: assert property (ct_stop |=> !ct_stop)
    else $error("stop pulse too long");
endmodule : irq_host_chk

bind uart_irq_and_host_access irq_host_chk u_chk (.mclk, .rstn,
  .chip_enable_low, .read_strobe_low, .data_oe, .rx_holding_read,
  .tx_holding_write, .ct_stop, .irq_out_low, .irq_mask_reg,
  .irq_status_reg);

// ### bench/uart_irq_and_host_access_tb_top.sv
`timescale 1ns/1ps
// ====
// self-checking bench
module uart_irq_and_host_access_tb_top;
  logic mclk, rstn, chip_enable_low, read_strobe_low, write_strobe_low;
  logic data_oe, rx_holding_read, tx_holding_write, ct_stop, irq_out_low;
  logic multi_purpose_in, chg, p, ct_start;
  logic [7:0] tx_holding_data;
  logic [7:0] starts = 8'h00;
  logic [2:0] host_addr;
  logic [7:0] data_in, data_out, irq_mask_reg, irq_status_reg, q, e, m;
  irq_ctl_pkg::cond_s cond;
  int fails, checked, seed, cyc;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = !mclk;
  end
  host_cpu_model u_host (.mclk, .chip_enable_low, .read_strobe_low,
    .write_strobe_low, .host_addr, .data_in, .data_out);
  uart_irq_and_host_access dut (.mclk, .rstn, .chip_enable_low,
    .read_strobe_low, .write_strobe_low, .host_addr, .data_in, .data_out,
    .data_oe, .cond, .multi_purpose_in, .rx_holding_read,
    .tx_holding_write, .tx_holding_data, .ct_start, .ct_stop,
    .irq_out_low, .irq_mask_reg, .irq_status_reg);
  // rest of controller: a holding access retires its condition
  always @(negedge mclk) begin
    if (rx_holding_read) cond.rx_ready = 1'b0;
    if (tx_holding_write) {cond.tx_ready, cond.tx_empty} = 2'b00;
    // start pulses counted mid-cycle, where the pulse has settled
    if (ct_start) starts = starts + 8'h01;
  end
  // hang guard, the run needs about 2800 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_host.access(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [2:0] a);
    u_host.access(1'b1, a, 8'h00, q);
  endtask : rd
  // waits from strobe release; the access already spent 30 cycles
  task automatic after_release(input int n);
    repeat (n - 30) @(negedge mclk);
  endtask : after_release
  task automatic print_verdict();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // ====
  // main sequence
  initial begin
    seed = 39;
    {rstn, multi_purpose_in, chg} = 3'h0;
    cond = '0;
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    check(irq_out_low, 1'b1);
    check(irq_mask_reg, irq_ctl_pkg::MASK_RESET);
    $display("reset test done");
    // random levels, corners: all enabled then none
    for (int i = 0; i < 12; i++) begin
      cond = 7'($random(seed)) & 7'h79;
      m = 8'($random(seed)) & 8'h7f;
      if (i < 2) m = i ? 8'h00 : 8'h7f;
      p = 1'($random(seed));
      chg = chg | (p ^ multi_purpose_in);
      multi_purpose_in = p;
      wr(3'h5, m);
      rd(3'h5);
      e = {1'b0, p, chg, 2'h0, cond.rx_ready | cond.rx_fifo_full,
        cond.tx_empty, cond.tx_ready};
      check(q, e);
      check(irq_mask_reg, m);
      check(irq_out_low, !(|(e & m)));
    end
    wr(3'h2, 8'hc0);
    rd(3'h5);
    check(q[5], 1'b0);
    $display("random test done");
    // event bits: raise, see pin fall, retire by command
    for (int i = 0; i < 3; i++) begin
      case (i)
        0: cond.break_det = 1'b1;
        1: cond.cnt_terminal = 1'b1;
        default: multi_purpose_in = !multi_purpose_in;
      endcase
      m = 8'h08 << i;
      wr(3'h5, m);
      rd(3'h5);
      check(q & m, m);
      check(irq_out_low, 1'b0);
      if (i == 1) begin
        wr(3'h2, 8'h80);
      end
      wr(3'h2, i == 0 ? 8'h50 : i == 1 ? 8'h90 : 8'hc0);
      after_release(irq_ctl_pkg::WITHDRAW_CYC);
      check(irq_out_low, 1'b1);
    end
    check(starts, 8'h01);
    $display("event test done");
    // holding accesses and mask clear withdraw the pin
    cond = 7'h70;
    wr(3'h5, 8'h04);
    check(irq_out_low, 1'b0);
    rd(3'h3);
    after_release(irq_ctl_pkg::WITHDRAW_CYC);
    check(irq_out_low, 1'b1);
    wr(3'h5, 8'h03);
    check(irq_out_low, 1'b0);
    e = 8'($random(seed));
    wr(3'h3, e);
    after_release(irq_ctl_pkg::WITHDRAW_CYC);
    check(irq_out_low, 1'b1);
    check(tx_holding_data, e);
    cond.tx_ready = 1'b1;
    wr(3'h5, 8'h01);
    check(irq_out_low, 1'b0);
    wr(3'h5, 8'h00);
    after_release(irq_ctl_pkg::MASK_WITHDRAW_CYC);
    check(irq_out_low, 1'b1);
    $display("withdraw test done");
    print_verdict();
  end
endmodule : uart_irq_and_host_access_tb_top

// ### hw/irq_ctl_pkg.sv
package irq_ctl_pkg;

  // =====================================================================
  // interrupt condition bit positions (status and mask share them)
  // =====================================================================
  localparam int IRQ_W = 8;
  localparam int BIT_TX_READY = 0;
  localparam int BIT_TX_EMPTY = 1;
  localparam int BIT_RX_READY = 2;
  localparam int BIT_BREAK_CHG = 3;
  localparam int BIT_CNT_READY = 4;
  localparam int BIT_MPI_CHG = 5;
  localparam int BIT_MPI_LEVEL = 6;
  localparam logic [7:0] USED_BITS = 8'h7f;

  // =====================================================================
  // register indices on the 3-bit host address
  // =====================================================================
  localparam logic [2:0] ADDR_COMMAND = 3'h2;
  localparam logic [2:0] ADDR_HOLDING = 3'h3;
  localparam logic [2:0] ADDR_IRQ = 3'h5;

  // =====================================================================
  // command codes in the upper nibble of a command write
  // =====================================================================
  localparam logic [3:0] CMD_RESET_BREAK = 4'h5;
  localparam logic [3:0] CMD_START_CT = 4'h8;
  localparam logic [3:0] CMD_STOP_CT = 4'h9;
  localparam logic [3:0] CMD_RESET_MPI = 4'hc;

  // =====================================================================
  // reset values and timing
  // =====================================================================
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WITHDRAW_NS = 370;
  localparam int MASK_WITHDRAW_NS = 270;
  // longest times round down to whole cycles
  localparam int WITHDRAW_CYC = (WITHDRAW_NS * 1000) / CLK_PERIOD_PS;
  localparam int MASK_WITHDRAW_CYC =
    (MASK_WITHDRAW_NS * 1000) / CLK_PERIOD_PS;

  // one host access as seen after synchronising
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] data;
  } host_req_s;

  // raw condition inputs from the rest of the controller
  typedef struct packed {
    logic tx_ready;
    logic tx_empty;
    logic rx_ready;
    logic rx_fifo_full;
    logic break_det;
    logic cnt_terminal;
    logic mpi_level;
  } cond_s;

endpackage : irq_ctl_pkg

// ### hw/uart_irq_and_host_access.sv
`timescale 1ns/1ps

// How it works
// - a read or write is live only while chip enable and its strobe are both low.
// - seven conditions can each pull the interrupt output.
// - the mask register chosen by software gates which conditions interrupt.
// - a status read returns every active condition whatever the mask.
// - reading the receive holding register drops the receive interrupt fast.
// - writing the transmit holding register drops both transmit interrupts.
// - the reset-break-change command drops that interrupt quickly.
// - the reset-input-change command drops that interrupt quickly.
// - the stop counter command drops the counter interrupt quickly.
// - clearing a mask bit drops the interrupt output within 270 ns.
module uart_irq_and_host_access (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // host parallel port pins
  input wire logic chip_enable_low,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // conditions from receiver, transmitter, counter and input pin
  input wire irq_ctl_pkg::cond_s cond,
  input wire logic multi_purpose_in,
  // access strobes to the rest of the controller
  output logic rx_holding_read,
  output logic tx_holding_write,
  output logic [7:0] tx_holding_data,
  output logic ct_start,
  output logic ct_stop,
  // interrupt pin and registers seen by the core
  output logic irq_out_low,
  output logic [7:0] irq_mask_reg,
  output logic [7:0] irq_status_reg
);

  // ===================================================================
  // pin synchronisers: three stages, change counts when 2 and 3 agree
  // ===================================================================
  localparam int PINS = 15;
  // strobes idle high, the rest idle low: a high reset value on the input
  // pin would look like an input change as soon as reset lets go
  localparam logic [PINS-1:0] PIN_IDLE = 15'h7000;
  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] s1;
  logic [PINS-1:0] s2;
  logic [PINS-1:0] s3;
  logic [PINS-1:0] pin_ok;
  assign pin_raw = {chip_enable_low, read_strobe_low, write_strobe_low,
                    host_addr, data_in, multi_purpose_in};

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_sync
      // each stage starts at the pin's idle level
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          s1[g] <= PIN_IDLE[g];
          s2[g] <= PIN_IDLE[g];
          s3[g] <= PIN_IDLE[g];
          pin_ok[g] <= PIN_IDLE[g];
        end else begin
          s1[g] <= pin_raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            pin_ok[g] <= s3[g];
          end
        end
      end
    end
  endgenerate

  // ===================================================================
  // strobe combine and edge detect
  // ===================================================================
  logic ce_n;
  logic rd_n;
  logic wr_n;
  logic mpi_s;
  irq_ctl_pkg::host_req_s req;
  logic rd_act;
  logic wr_act;
  logic rd_prev;
  logic wr_prev;
  logic rd_start;
  logic wr_end;
  assign ce_n = pin_ok[14];
  assign rd_n = pin_ok[13];
  assign wr_n = pin_ok[12];
  assign mpi_s = pin_ok[0];
  // the two active-low signals are ORed: last low opens, first high ends
  assign rd_act = !(ce_n | rd_n);
  assign wr_act = !(ce_n | wr_n);
  assign rd_start = rd_act && !rd_prev;
  // write data is latched as the access closes, like a strobe rising edge
  assign wr_end = !wr_act && wr_prev;

  // address and data held from the access so the write uses stable data
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      req <= '0;
    end else begin
      rd_prev <= rd_act;
      wr_prev <= wr_act;
      req.rd <= rd_start;
      req.wr <= wr_end;
      if (rd_act || wr_act) begin
        req.addr <= pin_ok[11:9];
        req.data <= pin_ok[8:1];
      end
    end
  end

  // ===================================================================
  // register decode
  // ===================================================================
  logic hit_irq;
  logic hit_hold;
  logic hit_cmd;
  logic wr_mask;
  logic wr_cmd;
  logic [3:0] cmd_code;
  assign hit_irq = (req.addr == irq_ctl_pkg::ADDR_IRQ);
  assign hit_hold = (req.addr == irq_ctl_pkg::ADDR_HOLDING);
  assign hit_cmd = (req.addr == irq_ctl_pkg::ADDR_COMMAND);
  assign wr_mask = req.wr && hit_irq;
  assign wr_cmd = req.wr && hit_cmd;
  assign cmd_code = req.data[7:4];

  // one-cycle pulses to the core; the host spaces command writes itself
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_holding_read <= 1'b0;
      tx_holding_write <= 1'b0;
      tx_holding_data <= 8'h00;
      ct_start <= 1'b0;
      ct_stop <= 1'b0;
    end else begin
      rx_holding_read <= req.rd && hit_hold;
      tx_holding_write <= req.wr && hit_hold;
      if (req.wr && hit_hold) begin
        tx_holding_data <= req.data;
      end
      ct_start <= wr_cmd && (cmd_code == irq_ctl_pkg::CMD_START_CT);
      ct_stop <= wr_cmd && (cmd_code == irq_ctl_pkg::CMD_STOP_CT);
    end
  end

  // ===================================================================
  // condition sources
  // ===================================================================
  logic brk_prev;
  logic mpi_prev;
  logic cnt_prev;
  logic brk_chg;
  logic mpi_chg;
  logic cnt_hit;
  logic rst_brk;
  logic rst_mpi;
  logic tx_hold_w;
  logic rx_hold_r;
  assign brk_chg = cond.break_det != brk_prev;
  assign mpi_chg = mpi_s != mpi_prev;
  assign cnt_hit = cond.cnt_terminal && !cnt_prev;
  assign rst_brk = wr_cmd && (cmd_code == irq_ctl_pkg::CMD_RESET_BREAK);
  assign rst_mpi = wr_cmd && (cmd_code == irq_ctl_pkg::CMD_RESET_MPI);
  assign tx_hold_w = req.wr && hit_hold;
  assign rx_hold_r = req.rd && hit_hold;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      brk_prev <= 1'b0;
      mpi_prev <= 1'b0;
      cnt_prev <= 1'b0;
    end else begin
      brk_prev <= cond.break_det;
      mpi_prev <= mpi_s;
      cnt_prev <= cond.cnt_terminal;
    end
  end

  // ===================================================================
  // status bits: levels follow the core or the input pin, events are sticky
  // ===================================================================
  logic [7:0] next_status;
  always_comb begin
    next_status = irq_status_reg & irq_ctl_pkg::USED_BITS;
    // a holding write hides ready/empty until the core updates its flags
    next_status[irq_ctl_pkg::BIT_TX_READY] =
      cond.tx_ready && !tx_hold_w;
    next_status[irq_ctl_pkg::BIT_TX_EMPTY] =
      cond.tx_empty && !tx_hold_w;
    next_status[irq_ctl_pkg::BIT_RX_READY] =
      (cond.rx_ready || cond.rx_fifo_full) && !rx_hold_r;
    next_status[irq_ctl_pkg::BIT_MPI_LEVEL] = mpi_s;
    // sticky events: a new event in the clear cycle wins
    if (rst_brk) begin
      next_status[irq_ctl_pkg::BIT_BREAK_CHG] = 1'b0;
    end
    if (brk_chg) begin
      next_status[irq_ctl_pkg::BIT_BREAK_CHG] = 1'b1;
    end
    if (rst_mpi) begin
      next_status[irq_ctl_pkg::BIT_MPI_CHG] = 1'b0;
    end
    if (mpi_chg) begin
      next_status[irq_ctl_pkg::BIT_MPI_CHG] = 1'b1;
    end
    if (ct_stop) begin
      next_status[irq_ctl_pkg::BIT_CNT_READY] = 1'b0;
    end
    if (cnt_hit) begin
      next_status[irq_ctl_pkg::BIT_CNT_READY] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_status_reg <= irq_ctl_pkg::STATUS_RESET;
    end else begin
      irq_status_reg <= next_status;
    end
  end

  // ===================================================================
  // mask register and interrupt pin
  // ===================================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_reg <= irq_ctl_pkg::MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_reg <= req.data & irq_ctl_pkg::USED_BITS;
    end
  end

  // pin follows the registered product, one cycle behind status and mask
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_out_low <= 1'b1;
    end else begin
      irq_out_low <= ~|(irq_status_reg & irq_mask_reg);
    end
  end

  // ===================================================================
  // read data: status is never masked
  // ===================================================================
  logic [7:0] rd_data;
  assign rd_data = hit_irq ? irq_status_reg : 8'h00;

  // data bus drives while a read is live; valid a few cycles in
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_oe <= rd_act;
      if (rd_act) begin
        data_out <= rd_data;
      end
    end
  end

endmodule : uart_irq_and_host_access
